/* logic/qqm_pkg.sv */
// package: constants, states and pointer helpers for the quad queue mux port
`default_nettype none
package qqm_pkg;
  localparam int QQM_NQ = 4;
  localparam int QQM_LW = 10;
  localparam int QQM_BW = 40;
  localparam int QQM_DENSITY = 327680;
  localparam int QQM_DEPTH = QQM_DENSITY / QQM_LW;
  localparam int QQM_AW = 15;
  localparam int QQM_CW = 2;
  localparam int QQM_EW = QQM_BW + QQM_CW;
  localparam logic [QQM_AW:0] QQM_PTR_ONE = 16'h0001;
  localparam logic [QQM_AW:0] QQM_FULL = 16'h8000;
  localparam logic [QQM_AW:0] QQM_AE_OFS = 16'h0007;
  localparam logic [QQM_AW:0] QQM_AF_LVL = 16'h7FF9;
  // strap encodings
  localparam logic [1:0] QQM_MD_MUX = 2'h0;
  localparam logic [1:0] QQM_MD_DEMUX = 2'h1;
  localparam logic [1:0] QQM_MD_BCAST = 2'h2;
  localparam logic [1:0] QQM_IW_X10 = 2'h0;
  localparam logic [1:0] QQM_IW_X20 = 2'h1;
  localparam logic [1:0] QQM_IW_X40 = 2'h2;
  // words in an entry, minus one
  localparam logic [1:0] QQM_CNT1 = 2'h0;
  localparam logic [1:0] QQM_CNT2 = 2'h1;
  localparam logic [1:0] QQM_CNT4 = 2'h3;
  // positions in the synchronised pin vector
  localparam int QQM_P_MRS = 0;
  localparam int QQM_P_PRS = 1;
  localparam int QQM_P_MD = 5;
  localparam int QQM_P_FT = 7;
  localparam int QQM_P_DDR = 8;
  localparam int QQM_P_IW = 9;
  localparam int QQM_PW = 11;
  localparam logic [QQM_PW-1:0] QQM_PIN_RST = 11'h000;
  typedef enum logic [1:0] {
    QQM_CFG_HOLD = 2'b01,
    QQM_CFG_RUN = 2'b10
  } qqm_cfg_state_t;

  function automatic logic [QQM_AW:0] qqm_bin2gray(input logic [QQM_AW:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [QQM_AW:0] qqm_gray2bin(input logic [QQM_AW:0] g);
    logic [QQM_AW:0] b;
    b[QQM_AW] = g[QQM_AW];
    for (int i = QQM_AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction
endpackage
`default_nettype wire

/* logic/qqm_queue.sv */
// one dual-clock queue with gray-coded pointer crossing
`default_nettype none
module qqm_queue
  import qqm_pkg::*;
(
  input wire logic arst_n_i,
  input wire logic wclk_i,
  input wire logic wr_clr_i,
  input wire logic wr_valid_i,
  input wire logic [QQM_EW-1:0] wr_data_i,
  output logic full_n_o,
  output logic almost_full_n_o,
  input wire logic clk_i,
  input wire logic rd_clr_i,
  input wire logic rd_pop_i,
  output logic [QQM_EW-1:0] rd_data_o,
  output logic rd_avail_o,
  output logic almost_empty_n_o
);
  logic [QQM_EW-1:0] mem_reg [QQM_DEPTH];
  logic [QQM_AW:0] wptr_reg;
  logic [QQM_AW:0] wgray_reg;
  logic [QQM_AW:0] rptr_reg;
  logic [QQM_AW:0] rgray_reg;
  logic [QQM_AW:0] rg_s1_reg;
  logic [QQM_AW:0] rg_s2_reg;
  logic [QQM_AW:0] wg_s1_reg;
  logic [QQM_AW:0] wg_s2_reg;
  logic [QQM_AW:0] wcount;
  logic [QQM_AW:0] rcount;
  logic push;
  logic pop;

  // ==========================================
  // write side
  assign wcount = wptr_reg - qqm_gray2bin(rg_s2_reg);
  assign full_n_o = (wcount != QQM_FULL);
  assign push = wr_valid_i & full_n_o & ~wr_clr_i;

  always_ff @(posedge wclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr_reg <= '0;
      wgray_reg <= '0;
    end else if (wr_clr_i) begin
      wptr_reg <= '0;
      wgray_reg <= '0;
    end else if (push) begin
      wptr_reg <= wptr_reg + QQM_PTR_ONE;
      wgray_reg <= qqm_bin2gray(wptr_reg + QQM_PTR_ONE);
    end
  end

  always_ff @(posedge wclk_i) begin
    if (push) begin
      mem_reg[wptr_reg[QQM_AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge wclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
      almost_full_n_o <= 1'b1;
    end else begin
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
      almost_full_n_o <= wr_clr_i | (wcount < QQM_AF_LVL);
    end
  end

  // ==========================================
  // read side
  assign rcount = qqm_gray2bin(wg_s2_reg) - rptr_reg;
  assign rd_avail_o = (rcount != '0) & ~rd_clr_i;
  assign pop = rd_pop_i & rd_avail_o;
  assign rd_data_o = mem_reg[rptr_reg[QQM_AW-1:0]];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rptr_reg <= '0;
      rgray_reg <= '0;
    end else if (rd_clr_i) begin
      rptr_reg <= qqm_gray2bin(wg_s2_reg);
      rgray_reg <= wg_s2_reg;
    end else if (pop) begin
      rptr_reg <= rptr_reg + QQM_PTR_ONE;
      rgray_reg <= qqm_bin2gray(rptr_reg + QQM_PTR_ONE);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
      almost_empty_n_o <= 1'b0;
    end else begin
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
      almost_empty_n_o <= ~rd_clr_i & (rcount > QQM_AE_OFS);
    end
  end
endmodule
`default_nettype wire

/* logic/qqm_mux_port.sv */
// quad queue mux port: config capture, four write lanes, shared read port
// ==========================================
`default_nettype none
module qqm_mux_port
  import qqm_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wclk_i,
  input wire logic master_reset_n_i,
  input wire logic [QQM_NQ-1:0] part_reset_n_i,
  input wire logic [1:0] operating_config_pins_i,
  input wire logic fall_through_cfg_i,
  input wire logic ddr_cfg_i,
  input wire logic [1:0] input_width_cfg_i,
  input wire logic [QQM_BW-1:0] wr_data_i,
  input wire logic [QQM_NQ-1:0] write_enable_n_i,
  input wire logic [QQM_NQ-1:0] write_select_n_i,
  input wire logic [1:0] output_queue_select_i,
  input wire logic read_enable_zero_n_i,
  input wire logic read_select_zero_n_i,
  output logic [QQM_LW-1:0] data_o,
  output logic [QQM_LW-1:0] data_fall_o,
  output logic out_ready_o,
  output logic [QQM_NQ-1:0] queue_empty_n_o,
  output logic [QQM_NQ-1:0] almost_empty_n_o,
  output logic [QQM_NQ-1:0] full_n_o,
  output logic [QQM_NQ-1:0] almost_full_n_o
);

  // ==========================================
  // pin synchronisers and strap capture
  logic [QQM_PW-1:0] pin_vec;
  logic [QQM_PW-1:0] pin_s1_reg;
  logic [QQM_PW-1:0] pin_s2_reg;
  logic [QQM_PW-1:0] pin_s3_reg;
  logic [QQM_PW-1:0] pin_reg;
  qqm_cfg_state_t cfg_state_reg;
  qqm_cfg_state_t cfg_state_next;
  logic [1:0] md_reg;
  logic [1:0] iw_reg;
  logic ft_reg;
  logic ddr_reg;
  logic mrs_act;
  logic mux_mode;
  logic [QQM_NQ-1:0] rclr_reg;

  assign pin_vec = {input_width_cfg_i, ddr_cfg_i, fall_through_cfg_i,
                    operating_config_pins_i, part_reset_n_i, master_reset_n_i};

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_reg <= QQM_PIN_RST;
      pin_s2_reg <= QQM_PIN_RST;
      pin_s3_reg <= QQM_PIN_RST;
      pin_reg <= QQM_PIN_RST;
    end else begin
      pin_s1_reg <= pin_vec;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      // a bit moves only once stages two and three agree
      pin_reg <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg ^ pin_s3_reg));
    end
  end

  assign mrs_act = ~pin_reg[QQM_P_MRS];

  always_comb begin
    case (cfg_state_reg)
      QQM_CFG_HOLD: cfg_state_next = mrs_act ? QQM_CFG_HOLD : QQM_CFG_RUN;
      QQM_CFG_RUN: cfg_state_next = mrs_act ? QQM_CFG_HOLD : QQM_CFG_RUN;
      default: cfg_state_next = QQM_CFG_HOLD;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_state_reg <= QQM_CFG_HOLD;
    end else begin
      cfg_state_reg <= cfg_state_next;
    end
  end

  // straps are only followed while held; the last value before release sticks
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      md_reg <= QQM_MD_MUX;
      iw_reg <= QQM_IW_X10;
      ft_reg <= 1'b0;
      ddr_reg <= 1'b0;
    end else if (cfg_state_reg == QQM_CFG_HOLD) begin
      md_reg <= pin_reg[QQM_P_MD +: 2];
      iw_reg <= pin_reg[QQM_P_IW +: 2];
      ft_reg <= pin_reg[QQM_P_FT];
      ddr_reg <= pin_reg[QQM_P_DDR];
    end
  end

  // broadcast has no read ports of its own here; it reads through this one
  assign mux_mode = (md_reg == QQM_MD_MUX) | (md_reg == QQM_MD_BCAST);

  // registered so the crossing into the write domain sees no glitch
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rclr_reg <= '1;
    end else begin
      for (int q = 0; q < QQM_NQ; q++) begin
        rclr_reg[q] <= (cfg_state_reg == QQM_CFG_HOLD) | ~pin_reg[QQM_P_PRS+q];
      end
    end
  end

  // ==========================================
  // crossing of clears and config into the write domain
  logic [QQM_NQ-1:0] wclr_s1_reg;
  logic [QQM_NQ-1:0] wclr_s2_reg;
  logic [4:0] wcfg_s1_reg;
  logic [4:0] wcfg_s2_reg;
  logic [1:0] w_md;
  logic [1:0] w_iw;
  logic w_ddr;

  always_ff @(posedge wclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wclr_s1_reg <= '1;
      wclr_s2_reg <= '1;
      wcfg_s1_reg <= '0;
      wcfg_s2_reg <= '0;
    end else begin
      wclr_s1_reg <= rclr_reg;
      wclr_s2_reg <= wclr_s1_reg;
      wcfg_s1_reg <= {ddr_reg, iw_reg, md_reg};
      wcfg_s2_reg <= wcfg_s1_reg;
    end
  end

  assign w_md = wcfg_s2_reg[1:0];
  assign w_iw = wcfg_s2_reg[3:2];
  assign w_ddr = wcfg_s2_reg[4];

  // ==========================================
  // write pipeline (write clock)
  logic [QQM_BW-1:0] fall_reg;
  logic [QQM_BW-1:0] s1_data_reg;
  logic [QQM_NQ-1:0] s1_en_reg;
  logic [QQM_NQ-1:0] s2_en_reg;
  logic [QQM_EW-1:0] s2_ent_reg [QQM_NQ];
  logic [QQM_EW-1:0] ent_next [QQM_NQ];
  logic [QQM_NQ-1:0] wport_en;
  logic [QQM_NQ-1:0] q_full_n;
  logic bc_ok;
  logic [1:0] bc_cnt;

  // data only on the falling edge; controls never sampled here
  always_ff @(negedge wclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fall_reg <= '0;
    end else begin
      fall_reg <= wr_data_i;
    end
  end

  assign wport_en = ~write_enable_n_i & ~write_select_n_i;
  // broadcast writes are dropped while any queue is full or being cleared
  assign bc_ok = (&q_full_n) & ~(|wclr_s2_reg);

  always_ff @(posedge wclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_en_reg <= '0;
      s1_data_reg <= '0;
    end else begin
      s1_data_reg <= wr_data_i;
      for (int q = 0; q < QQM_NQ; q++) begin
        if (w_md == QQM_MD_MUX) begin
          s1_en_reg[q] <= wport_en[q] & ~wclr_s2_reg[q];
        end else if (w_md == QQM_MD_BCAST) begin
          s1_en_reg[q] <= wport_en[0] & bc_ok;
        end else begin
          s1_en_reg[q] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    case (w_iw)
      QQM_IW_X40: bc_cnt = QQM_CNT4;
      QQM_IW_X20: bc_cnt = QQM_CNT2;
      default: bc_cnt = QQM_CNT1;
    endcase
  end

  always_comb begin
    for (int q = 0; q < QQM_NQ; q++) begin
      if (w_md == QQM_MD_BCAST) begin
        ent_next[q] = {bc_cnt, s1_data_reg};
      end else if (w_ddr) begin
        ent_next[q] = {QQM_CNT2, {(QQM_BW - 2 * QQM_LW){1'b0}},
                       fall_reg[q*QQM_LW +: QQM_LW],
                       s1_data_reg[q*QQM_LW +: QQM_LW]};
      end else begin
        ent_next[q] = {QQM_CNT1, {(QQM_BW - QQM_LW){1'b0}},
                       s1_data_reg[q*QQM_LW +: QQM_LW]};
      end
    end
  end

  // third rising edge writes the queue
  always_ff @(posedge wclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s2_en_reg <= '0;
      for (int q = 0; q < QQM_NQ; q++) begin
        s2_ent_reg[q] <= '0;
      end
    end else begin
      s2_en_reg <= s1_en_reg & ~wclr_s2_reg;
      for (int q = 0; q < QQM_NQ; q++) begin
        s2_ent_reg[q] <= ent_next[q];
      end
    end
  end

  // ==========================================
  // the four queues
  logic [QQM_EW-1:0] q_data [QQM_NQ];
  logic [QQM_NQ-1:0] q_avail;
  logic [QQM_NQ-1:0] q_pop;

  for (genvar gq = 0; gq < QQM_NQ; gq++) begin : g_queue
    qqm_queue u_queue (
      .arst_n_i(arst_n_i),
      .wclk_i(wclk_i),
      .wr_clr_i(wclr_s2_reg[gq]),
      .wr_valid_i(s2_en_reg[gq]),
      .wr_data_i(s2_ent_reg[gq]),
      .full_n_o(q_full_n[gq]),
      .almost_full_n_o(almost_full_n_o[gq]),
      .clk_i(clk_i),
      .rd_clr_i(rclr_reg[gq]),
      .rd_pop_i(q_pop[gq]),
      .rd_data_o(q_data[gq]),
      .rd_avail_o(q_avail[gq]),
      .almost_empty_n_o(almost_empty_n_o[gq])
    );
  end

  assign full_n_o = q_full_n;

  // ==========================================
  // head registers (read clock zero)
  logic [QQM_BW-1:0] hd_data_reg [QQM_NQ];
  logic [1:0] hd_left_reg [QQM_NQ];
  logic [QQM_NQ-1:0] hd_vld_reg;
  logic [QQM_BW-1:0] hd_data_next [QQM_NQ];
  logic [1:0] hd_left_next [QQM_NQ];
  logic [QQM_NQ-1:0] hd_vld_next;
  logic [QQM_BW-1:0] vis_data [QQM_NQ];
  logic [QQM_NQ-1:0] vis_vld;
  logic [QQM_NQ-1:0] consume;
  logic [QQM_NQ-1:0] done;
  logic [1:0] step_m1;
  logic [1:0] sel;
  logic rd_go;

  assign sel = output_queue_select_i;
  // only read port zero exists; the other read ports have no effect
  assign rd_go = mux_mode & ~read_enable_zero_n_i & ~read_select_zero_n_i
                 & hd_vld_reg[sel];
  assign step_m1 = ddr_reg ? QQM_CNT2 : QQM_CNT1;

  always_comb begin
    for (int q = 0; q < QQM_NQ; q++) begin
      consume[q] = rd_go & (sel == q[1:0]);
      done[q] = ~hd_vld_reg[q] | (consume[q] & (hd_left_reg[q] <= step_m1));
      q_pop[q] = done[q] & q_avail[q] & ~rclr_reg[q];
      // shifted head after this edge's read, excluding a fresh load
      vis_data[q] = ddr_reg ? (hd_data_reg[q] >> (2 * QQM_LW))
                            : (hd_data_reg[q] >> QQM_LW);
      vis_vld[q] = hd_vld_reg[q] & ~done[q];
      if (!consume[q]) begin
        vis_data[q] = hd_data_reg[q];
      end
      hd_data_next[q] = vis_data[q];
      hd_left_next[q] = consume[q] ? (hd_left_reg[q] - step_m1 - 2'h1) : hd_left_reg[q];
      hd_vld_next[q] = vis_vld[q];
      if (q_pop[q]) begin
        hd_data_next[q] = q_data[q][QQM_BW-1:0];
        hd_left_next[q] = q_data[q][QQM_EW-1:QQM_BW];
        hd_vld_next[q] = 1'b1;
      end
      if (rclr_reg[q]) begin
        hd_vld_next[q] = 1'b0;
      end
    end
  end

  // first queue stage: memory into the head
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hd_vld_reg <= '0;
      for (int q = 0; q < QQM_NQ; q++) begin
        hd_data_reg[q] <= '0;
        hd_left_reg[q] <= QQM_CNT1;
      end
    end else begin
      hd_vld_reg <= hd_vld_next;
      for (int q = 0; q < QQM_NQ; q++) begin
        hd_data_reg[q] <= hd_data_next[q];
        hd_left_reg[q] <= hd_left_next[q];
      end
    end
  end

  assign queue_empty_n_o = hd_vld_reg;

  // ==========================================
  // output stage: head onto the data lines
  // fall-through shows a word only one edge after it reaches the head, so a
  // freshly loaded entry costs one not-ready cycle after the last word
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_o <= '0;
      data_fall_o <= '0;
      out_ready_o <= 1'b0;
    end else begin
      out_ready_o <= mux_mode & vis_vld[sel];
      if (ft_reg) begin
        if (mux_mode & vis_vld[sel]) begin
          data_o <= vis_data[sel][QQM_LW-1:0];
          data_fall_o <= vis_data[sel][2*QQM_LW-1:QQM_LW];
        end
      end else if (rd_go) begin
        data_o <= hd_data_reg[sel][QQM_LW-1:0];
        data_fall_o <= hd_data_reg[sel][2*QQM_LW-1:QQM_LW];
      end
    end
  end
endmodule
`default_nettype wire

/* verif/qqm_mux_port_monitor.sv */
// checker: port-level properties of the quad queue mux port
`default_nettype none
module qqm_mux_port_monitor
  import qqm_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic master_reset_n_i,
  input wire logic fall_through_cfg_i,
  input wire logic [1:0] output_queue_select_i,
  input wire logic read_enable_zero_n_i,
  input wire logic read_select_zero_n_i,
  input wire logic [QQM_LW-1:0] data_o,
  input wire logic out_ready_o,
  input wire logic [QQM_NQ-1:0] queue_empty_n_o,
  input wire logic [QQM_NQ-1:0] almost_empty_n_o,
  input wire logic [QQM_NQ-1:0] full_n_o,
  input wire logic [QQM_NQ-1:0] almost_full_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // helper state
  logic ft_reg;
  logic [3:0] run_reg;
  logic run;
  logic idle;
  logic head;
  // run waits out the pin synchroniser and queue clears
  assign run = run_reg == 4'hF;
  assign idle = read_enable_zero_n_i | read_select_zero_n_i;
  assign head = queue_empty_n_o[output_queue_select_i];
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ft_reg <= 1'b0;
    end else if (!master_reset_n_i) begin
      ft_reg <= fall_through_cfg_i;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_reg <= 4'h0;
    end else if (!master_reset_n_i) begin
      run_reg <= 4'h0;
    end else if (!run) begin
      run_reg <= run_reg + 4'h1;
    end
  end
  // ======
  // properties
  default clocking cb @(posedge clk_i); endclocking
  sequence s_mrs_held;
    !master_reset_n_i [*8];
  endsequence
  sequence s_quiet;
    run && idle ##1 run && idle;
  endsequence
  property p_rst_flags;
    !arst_n_i |-> full_n_o == 4'hF && almost_full_n_o == 4'hF;
  endproperty
  property p_mrs_clear;
    disable iff (!arst_n_i) s_mrs_held |-> queue_empty_n_o == 4'h0 && almost_empty_n_o == 4'h0;
  endproperty
  property p_ae_empty;
    disable iff (!arst_n_i) (almost_empty_n_o & ~queue_empty_n_o) == 4'h0;
  endproperty
  property p_std_hold;
    disable iff (!arst_n_i) run && !ft_reg && idle |=> $stable(data_o);
  endproperty
  property p_std_empty;
    disable iff (!arst_n_i) run && !ft_reg && !idle && !head |=> $stable(data_o);
  endproperty
  property p_ft_nowr;
    disable iff (!arst_n_i)
      s_quiet ##0 (ft_reg && out_ready_o && $stable(output_queue_select_i)) |=> $stable(data_o);
  endproperty
  property p_ft_show;
    disable iff (!arst_n_i) s_quiet ##0 (ft_reg && head) |=> out_ready_o;
  endproperty
  property p_ft_none;
    disable iff (!arst_n_i) run && ft_reg && !head |=> !out_ready_o;
  endproperty
  a_rst_flags: assert property (p_rst_flags) else $error("flags wrong in reset");
  a_mrs_clear: assert property (p_mrs_clear) else $error("heads not cleared");
  a_ae_empty: assert property (p_ae_empty) else $error("almost empty high on empty");
  a_std_hold: assert property (p_std_hold) else $error("output moved without read");
  a_std_empty: assert property (p_std_empty) else $error("empty read moved output");
  a_ft_nowr: assert property (p_ft_nowr) else $error("later write fell through");
  a_ft_show: assert property (p_ft_show) else $error("selected word not shown");
  a_ft_none: assert property (p_ft_none) else $error("ready on empty queue");
endmodule

bind qqm_mux_port qqm_mux_port_monitor u_mon (
  .clk_i,
  .arst_n_i,
  .master_reset_n_i,
  .fall_through_cfg_i,
  .output_queue_select_i,
  .read_enable_zero_n_i,
  .read_select_zero_n_i,
  .data_o,
  .out_ready_o,
  .queue_empty_n_o,
  .almost_empty_n_o,
  .full_n_o,
  .almost_full_n_o
);
`default_nettype wire

/* verif/qqm_source.sv */
// partner: write-side source driving the four write lanes
`default_nettype none
module qqm_source
  import qqm_pkg::*;
(
  input wire logic wclk_i,
  output logic [QQM_BW-1:0] wr_data_o,
  output logic [QQM_NQ-1:0] write_enable_n_o,
  output logic [QQM_NQ-1:0] write_select_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_data_o = 40'h0;
    write_enable_n_o = 4'hF;
    write_select_n_o = 4'hF;
  end
  // ======
  // one write: change after falling edge, hold across rising edge
  // falling-edge word is the inverse, so released lanes never keep the old word
  task automatic put(input logic [3:0] en_n, input logic [3:0] cs_n, input logic [39:0] d);
    @(negedge wclk_i);
    wr_data_o <= d;
    write_enable_n_o <= en_n;
    write_select_n_o <= cs_n;
    @(posedge wclk_i);
    wr_data_o <= ~d;
    @(negedge wclk_i);
    write_enable_n_o <= 4'hF;
    write_select_n_o <= 4'hF;
  endtask
endmodule
`default_nettype wire

/* verif/qqm_mux_port_bench.sv */
// bench: self-checking test of the quad queue mux port
`default_nettype none
module qqm_mux_port_bench
  import qqm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic wclk_i = 1'b0;
  logic arst_n_i = 1'b1;
  logic ddr_cfg_i = 1'b0;
  logic [9:0] data_fall_o;
  logic master_reset_n_i = 1'b0;
  logic [3:0] part_reset_n_i = 4'hF;
  logic [1:0] operating_config_pins_i = QQM_MD_MUX;
  logic fall_through_cfg_i = 1'b1;
  logic [1:0] input_width_cfg_i = QQM_IW_X10;
  logic [1:0] output_queue_select_i = 2'h0;
  logic read_enable_zero_n_i = 1'b1;
  logic read_select_zero_n_i = 1'b1;
  logic [39:0] wr_data_i;
  logic [3:0] write_enable_n_i;
  logic [3:0] write_select_n_i;
  logic [9:0] data_o;
  logic out_ready_o;
  logic [3:0] queue_empty_n_o;
  logic [3:0] full_n_o;
  int miscompares = 0;
  int tests_run = 0;
  logic [31:0] lfsr = 32'h0001_4EF0;
  logic [39:0] w;
  logic [39:0] w2;
  logic [9:0] d0;
  logic [9:0] ex [4];
  always #12.5 clk_i = ~clk_i;
  always #32 wclk_i = ~wclk_i;
  qqm_mux_port dut (
    .clk_i, .arst_n_i, .wclk_i, .master_reset_n_i, .part_reset_n_i,
    .operating_config_pins_i, .fall_through_cfg_i, .ddr_cfg_i, .input_width_cfg_i,
    .wr_data_i, .write_enable_n_i, .write_select_n_i, .output_queue_select_i,
    .read_enable_zero_n_i, .read_select_zero_n_i, .data_o, .data_fall_o, .out_ready_o,
    .queue_empty_n_o, .almost_empty_n_o(), .full_n_o, .almost_full_n_o()
  );
  qqm_source src (
    .wclk_i, .wr_data_o(wr_data_i), .write_enable_n_o(write_enable_n_i),
    .write_select_n_o(write_select_n_i)
  );
  // ======
  // helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [9:0] lane(input logic [39:0] d, input logic [1:0] q);
    return d[q*10 +: 10];
  endfunction
  task automatic rnd();
    lfsr = nxt(nxt(lfsr));
    w[39:20] = lfsr[19:0];
    lfsr = nxt(nxt(lfsr));
    w[19:0] = lfsr[19:0];
  endtask
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chkf(input logic [3:0] g, input logic [3:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wr(input logic [3:0] m, input logic [39:0] d);
    src.put(~m, ~m, d);
    cyc(1);
  endtask
  // bounded wait for a queue head, then let the output stage load
  task automatic wait_head(input logic [1:0] q);
    int i;
    i = 0;
    while (queue_empty_n_o[q] !== 1'b1 && i < 80) begin
      @(negedge clk_i);
      i++;
    end
    if (i == 80) begin
      miscompares++;
      report_and_stop();
    end
    cyc(2);
  endtask
  task automatic master_reset_n(input logic [1:0] md, input logic ft, input logic [1:0] iw);
    @(negedge clk_i);
    master_reset_n_i = 1'b0;
    operating_config_pins_i = md;
    fall_through_cfg_i = ft;
    input_width_cfg_i = iw;
    cyc(10);
    master_reset_n_i = 1'b1;
    cyc(16);
  endtask
  // one read edge; the trailing cycle keeps reads apart
  task automatic rd();
    read_enable_zero_n_i = 1'b0;
    read_select_zero_n_i = 1'b0;
    cyc(1);
    read_enable_zero_n_i = 1'b1;
    read_select_zero_n_i = 1'b1;
    cyc(1);
  endtask
  // ======
  // main sequence
  initial begin
    // a real falling edge, so every flop except the queue memories resets before the first clock edge
    #1;
    arst_n_i = 1'b0;
    cyc(5);
    arst_n_i = 1'b1;
    chkf(full_n_o, 4'hF);
    master_reset_n(QQM_MD_MUX, 1'b1, QQM_IW_X10);
    chkf(queue_empty_n_o, 4'h0);
    rnd();
    src.put(4'h0, 4'hF, w);
    src.put(4'hF, 4'h0, w);
    cyc(20);
    chkf(queue_empty_n_o, 4'h0);
    for (int q = 0; q < 4; q++) begin
      rnd();
      wr(4'h1 << q, w);
      ex[q] = lane(w, 2'(q));
      output_queue_select_i = 2'(q);
      wait_head(2'(q));
      chk(data_o, ex[q]);
    end
    chkf(queue_empty_n_o, 4'hF);
    for (int k = 0; k < 8; k++) begin
      lfsr = nxt(lfsr);
      output_queue_select_i = lfsr[1:0];
      cyc(1);
      chk(data_o, ex[lfsr[1:0]]);
    end
    output_queue_select_i = 2'h0;
    rnd();
    wr(4'h1, w);
    cyc(20);
    chk(data_o, ex[0]);
    rd();
    cyc(3);
    chk(data_o, lane(w, 2'h0));
    $display("done: fall-through mux");
    master_reset_n(QQM_MD_MUX, 1'b0, QQM_IW_X10);
    d0 = data_o;
    rd();
    chk(data_o, d0);
    rnd();
    wr(4'h2, w);
    output_queue_select_i = 2'h1;
    wait_head(2'h1);
    cyc(4);
    chk(data_o, d0);
    rd();
    chk(data_o, lane(w, 2'h1));
    w2 = w;
    rnd();
    wr(4'hC, w);
    wait_head(2'h3);
    output_queue_select_i = 2'h2;
    cyc(3);
    chk(data_o, lane(w2, 2'h1));
    output_queue_select_i = 2'h3;
    cyc(1);
    rd();
    chk(data_o, lane(w, 2'h3));
    $display("done: standard mux");
    for (int b = 0; b < 2; b++) begin
      master_reset_n(QQM_MD_BCAST, 1'b0, b == 0 ? QQM_IW_X20 : QQM_IW_X40);
      rnd();
      wr(4'h1, w);
      lfsr = nxt(lfsr);
      output_queue_select_i = lfsr[1:0];
      wait_head(lfsr[1:0]);
      for (int k = 0; k < 2 + 2 * b; k++) begin
        rd();
        chk(data_o, lane(w, 2'(k)));
      end
      cyc(6);
      chkf(queue_empty_n_o, 4'hF ^ (4'h1 << lfsr[1:0]));
    end
    $display("done: broadcast");
    master_reset_n(QQM_MD_DEMUX, 1'b1, QQM_IW_X10);
    wr(4'hF, w);
    cyc(20);
    chkf(queue_empty_n_o, 4'h0);
    $display("done: demux writes ignored");
    ddr_cfg_i = 1'b1;
    master_reset_n(QQM_MD_MUX, 1'b0, QQM_IW_X10);
    rnd();
    output_queue_select_i = 2'h0;
    wr(4'h1, w);
    wait_head(2'h0);
    rd();
    chk(data_o, lane(w, 2'h0));
    chk(data_fall_o, lane(~w, 2'h0));
    chkf(queue_empty_n_o, 4'h0);
    $display("done: double data rate");
    report_and_stop();
  end
endmodule
`default_nettype wire
